/* hw/channel_phase_offset_regs.v */
// channel phase offset register bank with axi4-lite slave and adder
//
// How it works
// - offset is 16 bits, low byte then high
// - offsets apply only with downconversion, octal also needs continuous wave
// - all ones means about 359.995 degrees
// - 0x00ff means about 1.4 degrees
// - byte registers read/write, reset to zero
// - pairs map to sequence slots in order
// - code equals 65536 times degrees over 360
// - octal needs wave and conversion; single/dual conversion
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "phase_offset_defs.vh"

module channel_phase_offset_regs (
  input wire clock,
  input wire sys_rst,
  // axi4-lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // slot 0 low byte, kept by the neighbouring bank
  input wire [7:0] slot0_phase_offset_low,
  // oscillator phase stream
  input wire [15:0] osc_phase,
  input wire [2:0] sample_slot,
  input wire sample_valid,
  output reg [15:0] mixed_phase,
  output reg mixed_valid
);

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // word addressed map: byte address is four times the index, and
  // the two top address bits must be clear so that higher aliases
  // are refused rather than mirrored onto the bank
  // index to byte store position, none when not a phase byte
  function [2:0] pos_of;
    input [11:0] addr;
    reg [7:0] idx;
    begin
      idx = addr[9:2];
      pos_of = `POS_NONE;
      if (addr[11:10] == 2'h0 && idx >= `IDX_SLOT0_HIGH &&
          idx <= `IDX_SLOT3_HIGH) begin
        pos_of = idx[2:0] - 3'h7;
      end
    end
  endfunction

  // which register group an address hits
  function [1:0] sel_of;
    input [11:0] addr;
    begin
      if (pos_of(addr) != `POS_NONE) begin
        sel_of = `SEL_STORE;
      end else if (addr[11:10] == 2'h0 &&
                   addr[9:2] == `IDX_MODE_CTRL) begin
        sel_of = `SEL_CTRL;
      end else if (addr[11:10] == 2'h0 &&
                   addr[9:2] == `IDX_OFFSET_STATUS) begin
        sel_of = `SEL_STATUS;
      end else begin
        sel_of = `SEL_NONE;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg aw_held_q; // write address captured
  reg [11:0] aw_addr_q;
  reg w_held_q; // write data captured
  reg [31:0] w_data_q;
  reg w_lane0_q; // low byte lane enabled
  reg rd_pend_q; // read data being fetched
  reg [1:0] rd_sel_q; // group of pending read
  reg [3:0] mode_ctrl_q; // channel mode, wave and conversion enables
  reg offset_active_q; // offsets applied to the stream
  reg [15:0] last_offset_q; // offset of the last sample

  // handshake strobes, true in the cycle before the taking edge
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  wire [2:0] wr_pos = pos_of(aw_addr_q);
  wire [1:0] wr_sel = sel_of(aw_addr_q);
  wire store_wr = do_write && w_lane0_q && wr_sel == `SEL_STORE;
  wire [7:0] store_rd_data; // registered store read byte
  wire [55:0] store_bytes; // all stored bytes

  // ------------------------------------------------------------
  // byte store
  // ------------------------------------------------------------
  // only lane 0 carries a phase byte; with that lane off a write
  // is answered okay but leaves the store as it was
  phase_byte_store store (
    .clock(clock),
    .sys_rst(sys_rst),
    .wr_en(store_wr),
    .wr_pos(wr_pos),
    .wr_data(w_data_q[7:0]),
    .rd_en(ar_fire),
    .rd_pos(pos_of(s_axi_araddr)),
    .rd_data(store_rd_data),
    .all_bytes(store_bytes)
  );

  // ------------------------------------------------------------
  // write channels
  // ------------------------------------------------------------
  // address and data may come in either order; each is latched and
  // its ready dropped until the answer has been taken, so a master offering
  // one early is held off instead of losing the beat; the answer
  // follows one edge after the later of the two handshakes
  reg aw_held_d;
  reg w_held_d;
  reg bvalid_d;
  // next hold and response state
  always @* begin
    aw_held_d = aw_held_q || aw_fire;
    w_held_d = w_held_q || w_fire;
    bvalid_d = s_axi_bvalid && !s_axi_bready;
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
    end
  end

  // capture address and data in either order, then answer
  always @(posedge clock) begin
    if (sys_rst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      mode_ctrl_q <= `CTRL_RESET;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_awready <= !aw_held_d && !bvalid_d;
      s_axi_wready <= !w_held_d && !bvalid_d;
      if (aw_fire) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_data_q <= s_axi_wdata;
        w_lane0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        // status and unmapped addresses refuse writes
        if (wr_sel == `SEL_STORE || wr_sel == `SEL_CTRL) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
        // mode word lives in the low nibble of lane 0
        if (wr_sel == `SEL_CTRL && w_lane0_q) begin
          mode_ctrl_q <= w_data_q[3:0];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read channels
  // ------------------------------------------------------------
  // the byte store has a registered read port: its byte is caught at
  // the address handshake and forwarded one edge later, so rvalid
  // rises one edge after the handshake edge and arready stays low
  // until that answer has been taken
  reg rd_pend_d;
  reg rvalid_d;
  // next read state
  always @* begin
    rd_pend_d = ar_fire;
    rvalid_d = rd_pend_q || (s_axi_rvalid && !s_axi_rready);
  end

  // fetch one cycle, answer the next
  always @(posedge clock) begin
    if (sys_rst) begin
      rd_pend_q <= 1'b0;
      rd_sel_q <= `SEL_NONE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      rd_pend_q <= rd_pend_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_arready <= !rd_pend_d && !rvalid_d;
      if (ar_fire) begin
        rd_sel_q <= sel_of(s_axi_araddr);
      end
      if (rd_pend_q) begin
        s_axi_rresp <= `RESP_OKAY;
        // status: last offset used, and whether offsets apply
        case (rd_sel_q)
          `SEL_STORE: begin
            s_axi_rdata <= {24'h000000, store_rd_data};
          end
          `SEL_CTRL: begin
            s_axi_rdata <= {28'h0000000, mode_ctrl_q};
          end
          `SEL_STATUS: begin
            s_axi_rdata <= {last_offset_q, 15'h0000,
                            offset_active_q};
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // offset datapath
  // ------------------------------------------------------------
  wire down_conv_on = mode_ctrl_q[`CTRL_DOWNCONV_BIT]; // conversion enable
  wire cont_wave_on = mode_ctrl_q[`CTRL_CONTWAVE_BIT]; // wave enable
  wire [1:0] chmode = mode_ctrl_q[`CTRL_CHMODE_MSB:`CTRL_CHMODE_LSB];
  // eight-channel use shifts phase only with wave and conversion on
  wire octal_ok = down_conv_on && cont_wave_on &&
                  chmode == `CHMODE_OCTAL;
  // one- and two-channel use shifts phase whenever conversion runs
  wire narrow_ok = down_conv_on &&
                   (chmode == `CHMODE_SINGLE || chmode == `CHMODE_DUAL);
  // any other setting passes the oscillator phase through untouched
  wire apply_on = octal_ok || narrow_ok;

  // slot 0 keeps its low byte in the neighbouring bank, so that byte
  // comes in on a port; later slots are wholly local, and slots 4 to 7
  // are served elsewhere and get no offset here
  reg [15:0] slot_offset; // assembled offset for this sample
  // pick the byte pair of the sample's sequence slot
  always @* begin
    case (sample_slot)
      3'h0: slot_offset = {store_bytes[7:0],
                           slot0_phase_offset_low};
      3'h1: slot_offset = {store_bytes[23:16],
                           store_bytes[15:8]};
      3'h2: slot_offset = {store_bytes[39:32],
                           store_bytes[31:24]};
      3'h3: slot_offset = {store_bytes[55:48],
                           store_bytes[47:40]};
      default: slot_offset = 16'h0000;
    endcase
  end

  // the offset code maps one full turn onto 16 bits, so a 16-bit sum
  // wraps exactly once per turn: all ones lands just below a full
  // turn and never reaches it
  // modulo-65536 add: full scale wraps below one cycle
  always @(posedge clock) begin
    if (sys_rst) begin
      mixed_phase <= 16'h0000;
      mixed_valid <= 1'b0;
      offset_active_q <= 1'b0;
      last_offset_q <= 16'h0000;
    end else begin
      mixed_valid <= sample_valid;
      offset_active_q <= apply_on;
      if (sample_valid) begin
        if (apply_on) begin
          mixed_phase <= osc_phase + slot_offset;
          last_offset_q <= slot_offset;
        end else begin
          mixed_phase <= osc_phase;
          last_offset_q <= 16'h0000;
        end
      end
    end
  end

endmodule // channel_phase_offset_regs

/* hw/phase_byte_store.v */
// seven byte-wide phase offset registers with a registered read port
`timescale 1ns/1ns
`include "phase_offset_defs.vh"

module phase_byte_store (
  input wire clock,
  input wire sys_rst,
  input wire wr_en,          // one-cycle write strobe
  input wire [2:0] wr_pos,   // byte position 0..6
  input wire [7:0] wr_data,
  input wire rd_en,          // load read data
  input wire [2:0] rd_pos,
  output reg [7:0] rd_data,  // registered read data
  output wire [55:0] all_bytes // every byte, position 0 lowest
);

  // ------------------------------------------------------------
  // storage, one flop group per byte
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : bytes
      reg [7:0] val_q; // one byte of offset
      // zero at reset, loaded on a matching write
      always @(posedge clock) begin
        if (sys_rst) begin
          val_q <= `PHASE_BYTE_RESET;
        end else if (wr_en && wr_pos == g) begin
          val_q <= wr_data;
        end
      end
      assign all_bytes[g*8 +: 8] = val_q;
    end
  endgenerate

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  // read data held in a register, zero for no position
  always @(posedge clock) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      if (rd_pos < 3'h7) begin
        rd_data <= all_bytes[rd_pos*8 +: 8];
      end else begin
        rd_data <= 8'h00;
      end
    end
  end

endmodule // phase_byte_store

/* hw/phase_offset_defs.vh */
// constants for the channel phase offset register bank
`ifndef PHASE_OFFSET_DEFS_VH
`define PHASE_OFFSET_DEFS_VH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_SLOT0_HIGH 8'h87
`define IDX_SLOT1_LOW 8'h88
`define IDX_SLOT1_HIGH 8'h89
`define IDX_SLOT2_LOW 8'h8a
`define IDX_SLOT2_HIGH 8'h8b
`define IDX_SLOT3_LOW 8'h8c
`define IDX_SLOT3_HIGH 8'h8d
`define IDX_MODE_CTRL 8'h40
`define IDX_OFFSET_STATUS 8'h41

// ------------------------------------------------------------
// byte store positions and decode results
// ------------------------------------------------------------
`define POS_NONE 3'h7
`define SEL_NONE 2'h0
`define SEL_STORE 2'h1
`define SEL_CTRL 2'h2
`define SEL_STATUS 2'h3

// ------------------------------------------------------------
// mode control fields and reset values
// ------------------------------------------------------------
`define CTRL_DOWNCONV_BIT 0
`define CTRL_CONTWAVE_BIT 1
`define CTRL_CHMODE_LSB 2
`define CTRL_CHMODE_MSB 3
`define CHMODE_SINGLE 2'h0
`define CHMODE_DUAL 2'h1
`define CHMODE_OCTAL 2'h2
`define CTRL_RESET 4'h0
`define PHASE_BYTE_RESET 8'h00

// ------------------------------------------------------------
// status fields and bus answers
// ------------------------------------------------------------
`define STAT_ACTIVE_BIT 0
`define STAT_LAST_LSB 16
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* verification/channel_phase_offset_regs_tb.sv */
// self-checking bench for the phase offset register bank
`timescale 1ns/1ns
module channel_phase_offset_regs_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0, s_v = 1'b0;
  logic [11:0] aw_a = 12'h0, ar_a = 12'h0;
  logic [31:0] w_d = 32'h0;
  logic [3:0] w_s = 4'h0;
  logic [7:0] low0 = 8'h01; // slot 0 low byte from the other bank
  logic [15:0] ph = 16'h0;
  logic [2:0] slot = 3'h0;
  logic b_rdy = 1'b1, r_rdy = 1'b1; // response takers
  wire aw_r, w_r, b_v, ar_r, r_v, m_v;
  wire [1:0] b_resp, r_resp;
  wire [31:0] r_d;
  wire [15:0] m_ph;
  int mismatches = 0, checks_done = 0;
  logic [7:0] tv [7] = '{8'h80, 8'hff, 8'h00, 8'hff, 8'hff, 8'h34, 8'h12};
  logic [3:0] mv [6] = '{4'h1, 4'h5, 4'hb, 4'h9, 4'h2, 4'hd}; // mode words
  logic ap [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0}; // offsets used
  always #2 clock = ~clock;
  channel_phase_offset_regs dut_u (.clock(clock), .sys_rst(sys_rst),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v),
    .s_axi_wready(w_r), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
    .s_axi_bready(b_rdy), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
    .s_axi_rvalid(r_v), .s_axi_rready(r_rdy),
    .slot0_phase_offset_low(low0), .osc_phase(ph), .sample_slot(slot),
    .sample_valid(s_v), .mixed_phase(m_ph), .mixed_valid(m_v));
  // ------------------------------------------------------------
  // report and bus tasks
  // ------------------------------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // a wait that ran out ends the run
  task guard(input logic ok);
    if (ok !== 1'b1) begin
      mismatches++;
      end_sim;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    int n;
    n = 0;
    aw_a <= a;
    w_d <= d;
    w_s <= s;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (aw_v && aw_r) aw_v <= 1'b0;
      if (w_v && w_r) w_v <= 1'b0;
    end while (b_v !== 1'b1 && n < 40);
    guard(b_v);
    check(b_resp, er);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    ar_a <= a;
    ar_v <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (ar_v && ar_r) ar_v <= 1'b0;
    end while (r_v !== 1'b1 && n < 40);
    guard(r_v);
    check(r_d, e);
    check(r_resp, er);
  endtask
  // one sample in, mixed result seen one edge later
  task samp(input logic [2:0] sl, input logic [15:0] p,
    input logic [15:0] e);
    slot <= sl;
    ph <= p;
    s_v <= 1'b1;
    @(posedge clock);
    s_v <= 1'b0;
    @(posedge clock);
    check(m_v, 1'b1);
    check(m_ph, e);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    for (int i = 0; i < 7; i++)
      rd(12'h21c + 12'(4 * i), 32'h0, 2'h0);
    for (int i = 0; i < 7; i++)
      wr(12'h21c + 12'(4 * i), 32'hffffff30 + 32'(i), 4'hf,
         2'h0);
    for (int i = 0; i < 7; i++)
      rd(12'h21c + 12'(4 * i), 32'h30 + 32'(i), 2'h0);
    wr(12'h220, 32'h77, 4'h0, 2'h0);
    rd(12'h220, 32'h31, 2'h0);
    wr(12'h3fc, 32'h5, 4'hf, 2'h2);
    rd(12'h3fc, 32'h0, 2'h2);
    wr(12'h104, 32'h1, 4'hf, 2'h2);
    for (int i = 0; i < 7; i++)
      wr(12'h21c + 12'(4 * i), {24'h0, tv[i]}, 4'hf, 2'h0);
    // six mode words, applied or bypassed
    for (int k = 0; k < 6; k++) begin
      wr(12'h100, {28'h0, mv[k]}, 4'hf, 2'h0);
      samp(3'h1, 16'h0010, ap[k] ? 16'h010f : 16'h0010);
      rd(12'h104, ap[k] ? 32'h00ff0001 : 32'h0, 2'h0);
    end
    wr(12'h100, 32'h1, 4'hf, 2'h0);
    samp(3'h0, 16'h1000, 16'h9001);
    samp(3'h2, 16'h0100, 16'h00ff);
    samp(3'h3, 16'h0001, 16'h1235);
    samp(3'h4, 16'h4444, 16'h4444);
    // answers stand until the bench takes them
    b_rdy <= 1'b0;
    r_rdy <= 1'b0;
    wr(12'h234, 32'h56, 4'hf, 2'h0);
    rd(12'h234, 32'h56, 2'h0);
    b_rdy <= 1'b1;
    r_rdy <= 1'b1;
    @(posedge clock);
    check({b_v, r_v}, 2'b11);
    check(r_d, 32'h56);
    @(posedge clock);
    check({b_v, r_v}, 2'b00);
    end_sim;
  end
endmodule // channel_phase_offset_regs_tb

/* verification/phase_regs_asserts.sv */
// bus and datapath timing checks for the phase offset bank
`timescale 1ns/1ns
module phase_regs_asserts (
  input wire clock,
  input wire sys_rst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire sample_valid,
  input wire mixed_valid,
  input wire [15:0] mixed_phase
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  chk_b_latency: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two edges after request");
  chk_r_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read answer not two edges after request");
  chk_w_block: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while answer pending");
  chk_r_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready while answer pending");
  chk_b_done: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not reopened");
  chk_r_done: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not reopened");
  chk_b_stand: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid)
    else $error("write answer dropped before taken");
  chk_r_stand: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid)
    else $error("read answer dropped before taken");
  // ------------------------------------------------------------
  // sample stream
  // ------------------------------------------------------------
  chk_mix_follow: assert property (sample_valid |=> mixed_valid)
    else $error("mixed sample missing");
  chk_mix_idle: assert property (!sample_valid |=> !mixed_valid)
    else $error("mixed sample without input");
  chk_mix_hold: assert property (
    !sample_valid |=> $stable(mixed_phase))
    else $error("mixed phase moved without sample");
endmodule // phase_regs_asserts

bind channel_phase_offset_regs phase_regs_asserts chk_u (.clock,
  .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .sample_valid, .mixed_valid, .mixed_phase);
